//--- rtl/prc_pkg.sv
/*
  Shared constants and types of the rail command handler: command codes, page values,
  field positions of the control bytes, reset values and timing counts.
  Assumes a core clock of 125 MHz; the design files that use names here refer to them by prc_pkg::name.
*/
package prc_pkg;

  // ----------------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------------
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_START_CFG = 8'h02;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STORE_USER = 8'h15;
  localparam logic [7:0] CMD_RESTORE_USER = 8'h16;
  localparam logic [7:0] CMD_VOUT_TARGET = 8'h21;
  localparam logic [7:0] CMD_VOUT_MAX = 8'h24;

  // ----------------------------------------------------------------------------
  // Page selector values and reset
  // ----------------------------------------------------------------------------
  localparam logic [7:0] PAGE_PH2 = 8'h00;
  localparam logic [7:0] PAGE_PH1 = 8'h01;
  localparam logic [7:0] PAGE_BOTH = 8'hFF;
  localparam logic [7:0] PAGE_RESET = 8'h00;

  // ----------------------------------------------------------------------------
  // On/off control byte layout and encodings
  // ----------------------------------------------------------------------------
  localparam int OP_STATE_HI = 7;
  localparam int OP_STATE_LO = 6;
  localparam int OP_MARGIN_HI = 5;
  localparam int OP_MARGIN_LO = 4;
  localparam int OP_UNUSED_HI = 3;
  localparam logic [7:0] OP_RESET = 8'h00;
  localparam logic [1:0] OPST_IMM_OFF = 2'h0;
  localparam logic [1:0] OPST_SOFT_OFF = 2'h1;
  localparam logic [1:0] OPST_ON = 2'h2;
  localparam logic [1:0] MARGIN_NOMINAL = 2'h0;
  localparam logic [1:0] MARGIN_LOW = 2'h1;
  localparam logic [1:0] MARGIN_HIGH = 2'h2;

  // ----------------------------------------------------------------------------
  // Start-configuration byte layout and encodings
  // ----------------------------------------------------------------------------
  localparam int CFG_IMM_BIT = 0;
  localparam int CFG_POL_BIT = 1;
  localparam int CFG_SRC_HI = 4;
  localparam int CFG_SRC_LO = 2;
  localparam logic [2:0] SRC_EN_ONLY = 3'h5;
  localparam logic [2:0] SRC_OP_ONLY = 3'h6;
  localparam logic [7:0] CFG_RESET = 8'h17;

  // ----------------------------------------------------------------------------
  // Security level, clamp ratio and timing
  // ----------------------------------------------------------------------------
  localparam logic [7:0] SECURITY_RESET = 8'h00;
  localparam logic [7:0] SECURITY_AFTER_RESTORE = 8'h01;
  localparam logic [6:0] CLAMP_PERCENT = 7'd115;
  localparam logic [22:0] PERCENT_DIV = 23'd100;
  localparam int CLK_MHZ = 125;
  localparam int NV_BUSY_MS = 100;
  localparam int TOFF_RAMP_US = 1000;
  localparam int NV_BUSY_CYCLES = NV_BUSY_MS * 1000 * CLK_MHZ;
  localparam int TOFF_RAMP_CYCLES = TOFF_RAMP_US * CLK_MHZ;

  typedef logic [23:0] prc_cnt_t;

  typedef enum logic [1:0] {
    PRC_RAIL_OFF = 2'b00,
    PRC_RAIL_ON = 2'b01,
    PRC_RAIL_SOFT_OFF = 2'b10
  } prc_rail_t;

  typedef enum logic [1:0] {
    PRC_NV_IDLE = 2'b00,
    PRC_NV_STORE = 2'b01,
    PRC_NV_RESTORE = 2'b10
  } prc_nv_t;

endpackage

//--- rtl/prc_sync2.sv
/*
  Two flip-flop synchroniser for levels and toggles of any width.
  Assumes each bit is independent or changes one at a time (toggles, static straps).
*/
module prc_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } prc_sync_st_t;

  prc_sync_st_t s_q;
  prc_sync_st_t s_d;

  // The first stage feeds only the second stage.
  always_comb begin
    s_d.meta = d;
    s_d.stable = s_q.meta;
  end

  // Synchronous clear of both stages.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.stable;

endmodule

//--- rtl/prc_link_port.sv
/*
  Link-clock end of the command path: takes one command from the bus controller,
  hands it to the core by a toggle handshake and returns the core's answer.
  Assumes the core holds its answer fields stable from its toggle until the next request.
*/
module prc_link_port (
  input wire logic link_clk,
  input wire logic sys_rst,
  input wire logic lk_req_valid,
  input wire logic lk_req_write,
  input wire logic [7:0] lk_req_code,
  input wire logic [15:0] lk_req_wdata,
  output logic lk_req_ready,
  output logic lk_rsp_valid,
  output logic [15:0] lk_rsp_rdata,
  output logic lk_rsp_nack,
  output logic lk_rsp_err,
  output logic hold_write,
  output logic [7:0] hold_code,
  output logic [15:0] hold_wdata,
  output logic req_tog,
  input wire logic rsp_tog,
  input wire logic [15:0] rsp_rdata,
  input wire logic rsp_nack,
  input wire logic rsp_err
);

  typedef struct packed {
    logic ready;
    logic req_tog;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
    logic rsp_seen;
    logic rsp_valid;
    logic [15:0] rdata;
    logic nack;
    logic err;
  } prc_link_st_t;

  prc_link_st_t s_q;
  prc_link_st_t s_d;
  logic link_rst;
  logic rsp_tog_s;

  // Reset and answer toggle brought into the link domain.
  prc_sync2 #(.W(1)) u_rst_sync (
    .clk(link_clk),
    .rst(1'b0),
    .d(sys_rst),
    .q(link_rst)
  );

  prc_sync2 #(.W(1)) u_rsp_sync (
    .clk(link_clk),
    .rst(link_rst),
    .d(rsp_tog),
    .q(rsp_tog_s)
  );

  // One command in flight; the hold fields stay put until the answer returns.
  always_comb begin
    s_d = s_q;
    s_d.rsp_valid = 1'b0;
    if (lk_req_valid && s_q.ready) begin
      s_d.write = lk_req_write;
      s_d.code = lk_req_code;
      s_d.wdata = lk_req_wdata;
      s_d.req_tog = ~s_q.req_tog;
      s_d.ready = 1'b0;
    end
    if (rsp_tog_s != s_q.rsp_seen) begin
      s_d.rsp_seen = rsp_tog_s;
      s_d.rsp_valid = 1'b1;
      s_d.rdata = rsp_rdata;
      s_d.nack = rsp_nack;
      s_d.err = rsp_err;
      s_d.ready = 1'b1;
    end
  end

  // State register of the link end.
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      s_q <= '0;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign lk_req_ready = s_q.ready;
  assign lk_rsp_valid = s_q.rsp_valid;
  assign lk_rsp_rdata = s_q.rdata;
  assign lk_rsp_nack = s_q.nack;
  assign lk_rsp_err = s_q.err;
  assign hold_write = s_q.write;
  assign hold_code = s_q.code;
  assign hold_wdata = s_q.wdata;
  assign req_tog = s_q.req_tog;

endmodule

//--- rtl/prc_core.sv
/*
  Command handler of a two-phase converter: page selection, on/off and margin control,
  start configuration, fault clearing with alert, user store save and restore, voltage target.
  Assumes commands arrive already decoded from the bus on link_clk; pins are asynchronous.
*/
module prc_core #(
  parameter int unsigned NV_BUSY_CYCLES = prc_pkg::NV_BUSY_CYCLES,
  parameter int unsigned TOFF_RAMP_CYCLES = prc_pkg::TOFF_RAMP_CYCLES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic lk_req_valid,
  input wire logic lk_req_write,
  input wire logic [7:0] lk_req_code,
  input wire logic [15:0] lk_req_wdata,
  output logic lk_req_ready,
  output logic lk_rsp_valid,
  output logic [15:0] lk_rsp_rdata,
  output logic lk_rsp_nack,
  output logic lk_rsp_err,
  input wire logic enable_pin,
  input wire logic [1:0] fault_condition,
  input wire logic [15:0] voltage_strap_setting,
  output logic [1:0] rail_enable,
  output logic [15:0] ph1_vout_target,
  output logic [15:0] ph2_vout_target,
  output logic [1:0] ph1_margin,
  output logic [1:0] ph2_margin,
  output logic [1:0] fault_status,
  output logic alert_output_pin_n,
  output logic [7:0] security_level,
  output logic nv_busy
);

  localparam prc_pkg::prc_cnt_t NV_LOAD = prc_pkg::prc_cnt_t'(NV_BUSY_CYCLES - 1);
  localparam prc_pkg::prc_cnt_t RAMP_LOAD = prc_pkg::prc_cnt_t'(TOFF_RAMP_CYCLES - 1);

  // ----------------------------------------------------------------------------
  // State of the core
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] page;
    logic [1:0][7:0] op;
    logic [1:0][7:0] cfg;
    logic [1:0][15:0] vout;
    logic [1:0][15:0] vmax;
    logic nv_valid;
    logic [1:0][7:0] nv_cfg;
    logic [1:0][15:0] nv_vout;
    logic [1:0][15:0] nv_vmax;
    prc_pkg::prc_nv_t nv_op;
    prc_pkg::prc_cnt_t nv_cnt;
    logic nv_busy;
    prc_pkg::prc_rail_t [1:0] rail;
    prc_pkg::prc_cnt_t [1:0] ramp_cnt;
    logic [1:0] lock_off;
    logic [1:0] rail_en;
    logic [1:0][1:0] margin;
    logic [1:0] fault;
    logic alert_n;
    logic [7:0] sec;
    logic req_seen;
    logic rsp_tog;
    logic [15:0] rsp_data;
    logic rsp_nack;
    logic rsp_err;
  } prc_core_st_t;

  prc_core_st_t s_q;
  prc_core_st_t s_d;

  logic hold_write;
  logic [7:0] hold_code;
  logic [15:0] hold_wdata;
  logic req_tog;
  logic req_s;
  logic [18:0] pins_s;
  logic [15:0] strap_s;
  logic en_s;
  logic [1:0] fault_s;
  logic [22:0] strap_prod;
  logic [22:0] strap_quot;
  logic [15:0] strap115;
  logic [1:0][15:0] vlimit;
  logic [1:0] want_on;
  logic [1:0] imm_op;
  logic [1:0] imm_off;

  // ----------------------------------------------------------------------------
  // Link end and crossings
  // ----------------------------------------------------------------------------
  prc_link_port u_link (
    .link_clk(link_clk),
    .sys_rst(sys_rst),
    .lk_req_valid(lk_req_valid),
    .lk_req_write(lk_req_write),
    .lk_req_code(lk_req_code),
    .lk_req_wdata(lk_req_wdata),
    .lk_req_ready(lk_req_ready),
    .lk_rsp_valid(lk_rsp_valid),
    .lk_rsp_rdata(lk_rsp_rdata),
    .lk_rsp_nack(lk_rsp_nack),
    .lk_rsp_err(lk_rsp_err),
    .hold_write(hold_write),
    .hold_code(hold_code),
    .hold_wdata(hold_wdata),
    .req_tog(req_tog),
    .rsp_tog(s_q.rsp_tog),
    .rsp_rdata(s_q.rsp_data),
    .rsp_nack(s_q.rsp_nack),
    .rsp_err(s_q.rsp_err)
  );

  prc_sync2 #(.W(1)) u_req_sync (
    .clk(mclk),
    .rst(sys_rst),
    .d(req_tog),
    .q(req_s)
  );

  prc_sync2 #(.W(19)) u_pin_sync (
    .clk(mclk),
    .rst(sys_rst),
    .d({voltage_strap_setting, enable_pin, fault_condition}),
    .q(pins_s)
  );

  assign strap_s = pins_s[18:3];
  assign en_s = pins_s[2];
  assign fault_s = pins_s[1:0];

  // Ceiling of the voltage target from the strap, saturated to 16 bits.
  always_comb begin
    strap_prod = 23'(strap_s) * 23'(prc_pkg::CLAMP_PERCENT);
    strap_quot = strap_prod / prc_pkg::PERCENT_DIV;
    strap115 = (|strap_quot[22:16]) ? 16'hFFFF : strap_quot[15:0];
  end

  // ----------------------------------------------------------------------------
  // Per-phase start decision and clamp limit
  // ----------------------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_phase
    always_comb begin
      case (s_q.cfg[i][prc_pkg::CFG_SRC_HI:prc_pkg::CFG_SRC_LO])
        prc_pkg::SRC_EN_ONLY: want_on[i] = en_s;
        prc_pkg::SRC_OP_ONLY: want_on[i] = (s_q.op[i][prc_pkg::OP_STATE_HI:prc_pkg::OP_STATE_LO] == prc_pkg::OPST_ON);
        default: want_on[i] = en_s && (s_q.op[i][prc_pkg::OP_STATE_HI:prc_pkg::OP_STATE_LO] == prc_pkg::OPST_ON);
      endcase
      imm_op[i] = (s_q.cfg[i][prc_pkg::CFG_SRC_HI:prc_pkg::CFG_SRC_LO] != prc_pkg::SRC_EN_ONLY) &&
                  (s_q.op[i][prc_pkg::OP_STATE_HI:prc_pkg::OP_STATE_LO] == prc_pkg::OPST_IMM_OFF);
      imm_off[i] = s_q.cfg[i][prc_pkg::CFG_IMM_BIT] || imm_op[i];
      vlimit[i] = (s_q.vmax[i] > strap115) ? s_q.vmax[i] : strap115;
    end
  end

  // ----------------------------------------------------------------------------
  // Command execution, store timer, rail sequencing and faults
  // ----------------------------------------------------------------------------
  always_comb begin
    logic [1:0] sel;
    logic rd_ph;
    logic clr;
    logic op_ok;
    logic [1:0] top;
    logic [1:0] mrg;
    sel = 2'b00;
    rd_ph = 1'b0;
    clr = 1'b0;
    op_ok = 1'b0;
    top = hold_wdata[prc_pkg::OP_STATE_HI:prc_pkg::OP_STATE_LO];
    mrg = hold_wdata[prc_pkg::OP_MARGIN_HI:prc_pkg::OP_MARGIN_LO];
    s_d = s_q;

    // Phase mask of the current page; reads of both phases return phase one.
    case (s_q.page)
      prc_pkg::PAGE_PH2: sel = 2'b10;
      prc_pkg::PAGE_PH1: sel = 2'b01;
      prc_pkg::PAGE_BOTH: sel = 2'b11;
      default: sel = 2'b00;
    endcase
    rd_ph = (s_q.page == prc_pkg::PAGE_PH2);

    // Only the listed on/off encodings are accepted.
    if (top == prc_pkg::OPST_ON) begin
      op_ok = (mrg != 2'h3) && (hold_wdata[prc_pkg::OP_UNUSED_HI:0] == 4'h0);
    end else if (top != 2'h3) begin
      op_ok = (hold_wdata[prc_pkg::OP_MARGIN_HI:0] == 6'h00);
    end

    // A new command gets exactly one answer; while storing it is refused.
    if (req_s != s_q.req_seen) begin
      s_d.req_seen = req_s;
      s_d.rsp_tog = ~s_q.rsp_tog;
      s_d.rsp_data = 16'h0000;
      s_d.rsp_nack = 1'b0;
      s_d.rsp_err = 1'b0;
      if (s_q.nv_op != prc_pkg::PRC_NV_IDLE) begin
        s_d.rsp_nack = 1'b1;
      end else if (hold_write) begin
        case (hold_code)
          prc_pkg::CMD_PAGE: begin
            if (hold_wdata[7:0] == prc_pkg::PAGE_PH2 || hold_wdata[7:0] == prc_pkg::PAGE_PH1 ||
                hold_wdata[7:0] == prc_pkg::PAGE_BOTH) begin
              s_d.page = hold_wdata[7:0];
            end else begin
              s_d.rsp_err = 1'b1;
            end
          end
          prc_pkg::CMD_OPERATION: begin
            if (!op_ok) begin
              s_d.rsp_err = 1'b1;
            end
            for (int i = 0; i < 2; i++) begin
              if (op_ok && sel[i]) begin
                s_d.op[i] = hold_wdata[7:0];
              end
            end
          end
          prc_pkg::CMD_START_CFG: begin
            if (hold_wdata[prc_pkg::CFG_SRC_HI:prc_pkg::CFG_SRC_LO] != prc_pkg::SRC_EN_ONLY &&
                hold_wdata[prc_pkg::CFG_SRC_HI:prc_pkg::CFG_SRC_LO] != prc_pkg::SRC_OP_ONLY) begin
              s_d.rsp_err = 1'b1;
            end else begin
              for (int i = 0; i < 2; i++) begin
                if (sel[i]) begin
                  s_d.cfg[i] = {3'h0, hold_wdata[prc_pkg::CFG_SRC_HI:prc_pkg::CFG_SRC_LO], 1'b1,
                                hold_wdata[prc_pkg::CFG_IMM_BIT]};
                end
              end
            end
          end
          prc_pkg::CMD_CLEAR_FAULTS: clr = 1'b1;
          prc_pkg::CMD_STORE_USER: begin
            s_d.nv_op = prc_pkg::PRC_NV_STORE;
            s_d.nv_cnt = NV_LOAD;
          end
          prc_pkg::CMD_RESTORE_USER: begin
            s_d.nv_op = prc_pkg::PRC_NV_RESTORE;
            s_d.nv_cnt = NV_LOAD;
          end
          prc_pkg::CMD_VOUT_TARGET: begin
            for (int i = 0; i < 2; i++) begin
              if (sel[i]) begin
                s_d.vout[i] = (hold_wdata > vlimit[i]) ? vlimit[i] : hold_wdata;
              end
            end
          end
          prc_pkg::CMD_VOUT_MAX: begin
            for (int i = 0; i < 2; i++) begin
              if (sel[i]) begin
                s_d.vmax[i] = hold_wdata;
              end
            end
          end
          default: s_d.rsp_err = 1'b1;
        endcase
      end else begin
        case (hold_code)
          prc_pkg::CMD_PAGE: s_d.rsp_data = {8'h00, s_q.page};
          prc_pkg::CMD_OPERATION: begin
            case (s_q.rail[rd_ph])
              prc_pkg::PRC_RAIL_ON: s_d.rsp_data = {8'h00, prc_pkg::OPST_ON, s_q.margin[rd_ph], 4'h0};
              prc_pkg::PRC_RAIL_SOFT_OFF: s_d.rsp_data = {8'h00, prc_pkg::OPST_SOFT_OFF, 6'h00};
              default: s_d.rsp_data = {8'h00, prc_pkg::OPST_IMM_OFF, 6'h00};
            endcase
          end
          prc_pkg::CMD_START_CFG: s_d.rsp_data = {8'h00, s_q.cfg[rd_ph]};
          prc_pkg::CMD_VOUT_TARGET: s_d.rsp_data = s_q.vout[rd_ph];
          prc_pkg::CMD_VOUT_MAX: s_d.rsp_data = s_q.vmax[rd_ph];
          default: s_d.rsp_err = 1'b1;
        endcase
      end
    end

    // Store and restore complete after the busy period; the control byte is left alone.
    if (s_q.nv_op != prc_pkg::PRC_NV_IDLE) begin
      if (s_q.nv_cnt == '0) begin
        if (s_q.nv_op == prc_pkg::PRC_NV_STORE) begin
          s_d.nv_cfg = s_q.cfg;
          s_d.nv_vout = s_q.vout;
          s_d.nv_vmax = s_q.vmax;
          s_d.nv_valid = 1'b1;
        end else begin
          for (int i = 0; i < 2; i++) begin
            s_d.cfg[i] = s_q.nv_valid ? s_q.nv_cfg[i] : prc_pkg::CFG_RESET;
            s_d.vout[i] = s_q.nv_valid ? s_q.nv_vout[i] : strap_s;
            s_d.vmax[i] = s_q.nv_valid ? s_q.nv_vmax[i] : strap115;
          end
          s_d.sec = prc_pkg::SECURITY_AFTER_RESTORE;
        end
        s_d.nv_op = prc_pkg::PRC_NV_IDLE;
      end else begin
        s_d.nv_cnt = s_q.nv_cnt - 1'b1;
      end
    end
    s_d.nv_busy = (s_d.nv_op != prc_pkg::PRC_NV_IDLE);

    // Rail sequencing; a fault shutdown stays off until the start request drops.
    for (int i = 0; i < 2; i++) begin
      if (!want_on[i]) begin
        s_d.lock_off[i] = 1'b0;
      end
      case (s_q.rail[i])
        prc_pkg::PRC_RAIL_OFF: begin
          if (want_on[i] && !s_q.lock_off[i]) begin
            s_d.rail[i] = prc_pkg::PRC_RAIL_ON;
          end
        end
        prc_pkg::PRC_RAIL_ON: begin
          if (fault_s[i]) begin
            s_d.rail[i] = prc_pkg::PRC_RAIL_OFF;
            s_d.lock_off[i] = 1'b1;
          end else if (!want_on[i]) begin
            if (imm_off[i]) begin
              s_d.rail[i] = prc_pkg::PRC_RAIL_OFF;
            end else begin
              s_d.rail[i] = prc_pkg::PRC_RAIL_SOFT_OFF;
              s_d.ramp_cnt[i] = RAMP_LOAD;
            end
          end
        end
        prc_pkg::PRC_RAIL_SOFT_OFF: begin
          if (fault_s[i]) begin
            s_d.rail[i] = prc_pkg::PRC_RAIL_OFF;
            s_d.lock_off[i] = 1'b1;
          end else if (imm_op[i] || s_q.ramp_cnt[i] == '0) begin
            s_d.rail[i] = prc_pkg::PRC_RAIL_OFF;
          end else begin
            s_d.ramp_cnt[i] = s_q.ramp_cnt[i] - 1'b1;
          end
        end
        default: s_d.rail[i] = prc_pkg::PRC_RAIL_OFF;
      endcase
      s_d.rail_en[i] = (s_d.rail[i] != prc_pkg::PRC_RAIL_OFF);
      s_d.margin[i] = (s_d.rail[i] == prc_pkg::PRC_RAIL_ON) ?
                      s_d.op[i][prc_pkg::OP_MARGIN_HI:prc_pkg::OP_MARGIN_LO] : prc_pkg::MARGIN_NOMINAL;
      s_d.fault[i] = (s_q.fault[i] && !clr) || fault_s[i];
    end
    s_d.alert_n = ~|s_d.fault;
  end

  // ----------------------------------------------------------------------------
  // State register; reset starts the power-up restore
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.page <= prc_pkg::PAGE_RESET;
      s_q.op <= {2{prc_pkg::OP_RESET}};
      s_q.cfg <= {2{prc_pkg::CFG_RESET}};
      s_q.nv_op <= prc_pkg::PRC_NV_RESTORE;
      s_q.nv_cnt <= NV_LOAD;
      s_q.nv_busy <= 1'b1;
      s_q.alert_n <= 1'b1;
      s_q.sec <= prc_pkg::SECURITY_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign rail_enable = s_q.rail_en;
  assign ph1_vout_target = s_q.vout[0];
  assign ph2_vout_target = s_q.vout[1];
  assign ph1_margin = s_q.margin[0];
  assign ph2_margin = s_q.margin[1];
  assign fault_status = s_q.fault;
  assign alert_output_pin_n = s_q.alert_n;
  assign security_level = s_q.sec;
  assign nv_busy = s_q.nv_busy;

endmodule

//--- testbench/prc_core_assertions.sv
/*
  Checker of the core's pins in the core clock domain.
  Assumes a bind to the core with its busy count handed on.
*/
module prc_core_assertions #(
  parameter int unsigned NV_BUSY_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [1:0] rail_enable,
  input wire logic [1:0] ph1_margin,
  input wire logic [1:0] ph2_margin,
  input wire logic [1:0] fault_condition,
  input wire logic [1:0] fault_status,
  input wire logic alert_output_pin_n,
  input wire logic [7:0] security_level,
  input wire logic nv_busy
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  logic [31:0] busy_q;
  // Counts the cycles of the running busy period.
  always_ff @(posedge mclk) begin
    busy_q <= (sys_rst || !nv_busy) ? 32'h0 : busy_q + 32'h1;
  end
  property p_rst_off; $fell(sys_rst) |-> rail_enable == 2'h0 && alert_output_pin_n; endproperty
  a_rst_off: assert property (p_rst_off) else $error("rail or alert active after reset");
  property p_alert; |fault_status |-> ##[0:1] !alert_output_pin_n; endproperty
  a_alert: assert property (p_alert) else $error("alert high with a fault bit set");
  property p_fault_set; fault_condition[1] [*5] |-> fault_status[1]; endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault bit clear while condition holds");
  property p_no_restart; $fell(fault_status[1]) && !rail_enable[1] |=> !rail_enable[1] [*4]; endproperty
  a_no_restart: assert property (p_no_restart) else $error("rail restarted by fault clear");
  property p_busy; $fell(nv_busy) |-> busy_q + 32'h1 >= NV_BUSY_CYCLES && busy_q <= NV_BUSY_CYCLES + 1; endproperty
  a_busy: assert property (p_busy) else $error("busy period of wrong length");
  property p_sec; $fell(nv_busy) |-> ##[0:1] security_level == 8'h01; endproperty
  a_sec: assert property (p_sec) else $error("security level not one after restore");
  property p_margin1; !rail_enable[0] |-> ##[0:1] ph1_margin == 2'h0; endproperty
  a_margin1: assert property (p_margin1) else $error("phase one margin while off");
  property p_margin2; !rail_enable[1] |-> ##[0:1] ph2_margin == 2'h0; endproperty
  a_margin2: assert property (p_margin2) else $error("phase two margin while off");
  c_busy: cover property ($fell(nv_busy));
  c_fault: cover property ($rose(fault_status[1]));
  c_both: cover property (rail_enable == 2'h3);
endmodule

//--- testbench/prc_host_model.sv
/*
  Host on the far side of the command link: makes the link clock, sends one command at a time.
  Assumes every taken request gets one answer pulse.
*/
module prc_host_model (
  output logic link_clk,
  output logic lk_req_valid,
  output logic lk_req_write,
  output logic [7:0] lk_req_code,
  output logic [15:0] lk_req_wdata,
  input wire logic lk_req_ready,
  input wire logic lk_rsp_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  logic run = 1'b1;
  // Link clock of 160 ns, off phase with the core, standing low between commands.
  initial begin
    link_clk = 1'b0;
    {lk_req_valid, lk_req_write, lk_req_code, lk_req_wdata} = 26'h0;
    #3.3;
    forever begin
      #80;
      if (run || link_clk)
        link_clk = ~link_clk;
    end
  end
  // Holds a request to its taking edge, scrambles released lines, awaits the answer.
  task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d);
    run = 1'b1;
    @(negedge link_clk);
    {lk_req_valid, lk_req_write, lk_req_code, lk_req_wdata} = {1'b1, w, c, d};
    @(posedge link_clk iff lk_req_ready === 1'b1);
    @(negedge link_clk);
    {lk_req_valid, lk_req_code, lk_req_wdata} = {1'b0, ~c, ~d};
    @(posedge link_clk iff lk_rsp_valid === 1'b1);
    @(negedge link_clk);
    run = 1'b0;
  endtask
endmodule

//--- testbench/test_pmbus_rail_command_handler.sv
/*
  Bench top: core, host model, pins and queued answer checks.
  Assumes short busy and ramp counts in the core.
*/
module test_pmbus_rail_command_handler;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic enable_pin = 1'b0;
  logic [1:0] fault_condition = 2'h0;
  logic [15:0] voltage_strap_setting = 16'h0;
  logic link_clk, lk_req_valid, lk_req_write, lk_req_ready, lk_rsp_valid, lk_rsp_nack, lk_rsp_err;
  logic [7:0] lk_req_code, security_level;
  logic [15:0] lk_req_wdata, lk_rsp_rdata, ph1_vout_target, ph2_vout_target;
  logic [1:0] rail_enable, ph1_margin, ph2_margin, fault_status;
  logic alert_output_pin_n, nv_busy;
  logic [17:0] exp_q[$];
  logic [31:0] lim;
  int seed = 32'hB7CA;
  int fail_count = 0;
  int check_count = 0;
  // Core clock.
  always #4 mclk = ~mclk;
  prc_host_model i_prc_host_model (.link_clk, .lk_req_valid, .lk_req_write, .lk_req_code, .lk_req_wdata,
    .lk_req_ready, .lk_rsp_valid);
  prc_core #(.NV_BUSY_CYCLES(400), .TOFF_RAMP_CYCLES(2000)) i_prc_core (.mclk, .sys_rst, .link_clk,
    .lk_req_valid, .lk_req_write, .lk_req_code, .lk_req_wdata, .lk_req_ready, .lk_rsp_valid,
    .lk_rsp_rdata, .lk_rsp_nack, .lk_rsp_err, .enable_pin, .fault_condition, .voltage_strap_setting,
    .rail_enable, .ph1_vout_target, .ph2_vout_target, .ph1_margin, .ph2_margin, .fault_status,
    .alert_output_pin_n, .security_level, .nv_busy);
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Notes the expected answer {nack, error, data}, then sends.
  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d, input logic [17:0] e);
    exp_q.push_back(e);
    i_prc_host_model.send(w, c, d);
    @(negedge mclk);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 1000 && nv_busy !== 1'b0; i++)
      @(negedge mclk);
    chk({17'h0, nv_busy}, 18'h0);
  endtask
  task automatic settle();
    repeat (6) @(negedge mclk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Each answer pulse is compared with the oldest note.
  always @(posedge link_clk) begin
    if (lk_rsp_valid === 1'b1)
      chk({lk_rsp_nack, lk_rsp_err, lk_rsp_rdata}, exp_q.size() > 0 ? exp_q.pop_front() : 18'h3FFFF);
  end
  // Cuts a hang short.
  initial begin
    #400000;
    fail_count++;
    give_verdict();
  end
  // Main sequence.
  initial begin
    voltage_strap_setting = 16'($random(seed)) & 16'h3FFF;
    lim = voltage_strap_setting * 32'h73 / 32'h64;
    repeat (12) @(posedge link_clk);
    @(negedge mclk);
    sys_rst = 1'b0;
    wait_idle();
    chk(18'(security_level), 18'h1);
    cmd(0, 8'h21, 16'h0, {2'h0, voltage_strap_setting});
    cmd(0, 8'h00, 16'h0, 18'h0);
    cmd(0, 8'h01, 16'h0, 18'h0);
    cmd(0, 8'h02, 16'h0, 18'h17);
    enable_pin = 1'b1;
    settle();
    chk(18'(rail_enable), 18'h3);
    enable_pin = 1'b0;
    settle();
    chk(18'(rail_enable), 18'h0);
    cmd(1, 8'h00, 16'h2, 18'h10000);
    cmd(1, 8'h00, 16'h1, 18'h0);
    cmd(1, 8'h02, 16'h18, 18'h0);
    cmd(1, 8'h01, 16'h80, 18'h0);
    chk(18'(rail_enable), 18'h1);
    cmd(1, 8'h00, 16'hFF, 18'h0);
    cmd(1, 8'h02, 16'h18, 18'h0);
    cmd(0, 8'h02, 16'h0, 18'h1A);
    cmd(1, 8'h01, 16'h50, 18'h10000);
    cmd(1, 8'h01, 16'h90, 18'h0);
    cmd(0, 8'h01, 16'h0, 18'h90);
    cmd(1, 8'h01, 16'hA0, 18'h0);
    chk({12'h0, ph2_margin, ph1_margin, rail_enable}, 18'h2B);
    fault_condition = 2'h2;
    settle();
    chk({14'h0, fault_status, alert_output_pin_n, rail_enable[1]}, 18'h8);
    cmd(1, 8'h03, 16'h0, 18'h0);
    chk({14'h0, fault_status, alert_output_pin_n, rail_enable[1]}, 18'h8);
    fault_condition = 2'h0;
    cmd(1, 8'h03, 16'h0, 18'h0);
    chk({14'h0, fault_status, alert_output_pin_n, rail_enable[1]}, 18'h2);
    cmd(1, 8'h01, 16'h40, 18'h0);
    cmd(0, 8'h01, 16'h0, 18'h40);
    cmd(1, 8'h01, 16'h0, 18'h0);
    cmd(0, 8'h01, 16'h0, 18'h0);
    cmd(1, 8'h15, 16'h0, 18'h0);
    cmd(0, 8'h00, 16'h0, 18'h20000);
    wait_idle();
    cmd(1, 8'h02, 16'h14, 18'h0);
    cmd(1, 8'h16, 16'h0, 18'h0);
    wait_idle();
    cmd(0, 8'h02, 16'h0, 18'h1A);
    cmd(0, 8'h01, 16'h0, 18'h0);
    cmd(1, 8'h21, 16'hFFFF, 18'h0);
    cmd(0, 8'h21, 16'h0, {2'h0, lim[15:0]});
    chk({2'h0, ph1_vout_target}, {2'h0, lim[15:0]});
    chk({2'h0, ph2_vout_target}, {2'h0, lim[15:0]});
    cmd(1, 8'h24, 16'hFFFF, 18'h0);
    cmd(1, 8'h21, 16'hFFFF, 18'h0);
    cmd(0, 8'h21, 16'h0, 18'hFFFF);
    give_verdict();
  end
endmodule
bind prc_core prc_core_assertions #(.NV_BUSY_CYCLES(NV_BUSY_CYCLES)) i_prc_core_assertions (.mclk, .sys_rst,
  .rail_enable, .ph1_margin, .ph2_margin, .fault_condition, .fault_status, .alert_output_pin_n,
  .security_level, .nv_busy);
